/* File: dcf_far_end.sv */
// writer and reader far-end model on free-running link clocks
`timescale 1ns/1ps
`default_nettype none
module dcf_far_end (
   // commands from the bench
   input  wire logic        wr_go,
   input  wire logic        rd_go,
   input  wire logic [35:0] wdata,
   // link side
   output logic             write_clk,
   output logic             read_clk,
   output logic             write_en_n,
   output logic             read_en_n,
   output logic      [35:0] write_data_in
);
   initial begin
      write_en_n = 1'b1;
      read_en_n = 1'b1;
      write_data_in = 36'h0;
      write_clk = 1'b0;
      forever #40 write_clk = ~write_clk;
   end
   initial begin
      read_clk = 1'b0;
      #17.3;
      forever #40 read_clk = ~read_clk;
   end
   // change away from the rising edge so the device sees stable levels
   always @(negedge write_clk) begin
      write_en_n <= !wr_go;
      write_data_in <= wdata;
   end
   always @(negedge read_clk) read_en_n <= !rd_go;
endmodule : dcf_far_end
`default_nettype wire

/* File: dcf_fifo_flags.sv */
// dual-clock 36-bit fifo with programmable flags, bus matching and straps
`timescale 1ns/1ps
`default_nettype none
// Contract
// - standard mode: almost-empty low when count is at or below offset n
// - fall-through mode: almost-empty low when count is at or below n+1
// - byte order sampled at master reset; low big-endian, high little-endian
// - width matching sends most significant piece first when big-endian
// - flag timing mode sampled at master reset; low async, high sync
// - async: almost flags asserted by one clock, released by the other
// - sync: almost-empty only on read clock, almost-full only on write clock
// - parity placement sampled at master reset; high means interspersed
// - parallel offset load skips parity bits or ignores the top nibble
// - parity placement never touches queued data
// - standard mode: full flag low when full, further writes refused
// - fall-through mode: input-ready high when full, capacity depth plus one
// - half-full set low by write edge, released high by read edge
// - standard mode: half-full low after depth/2 + 1 writes
// - fall-through mode: half-full low after depth/2 + 2 writes
// - output uses bits 0-35, 0-17 or 0-8 by output width
// - full/input-ready updated on write clock through two register stages
module dcf_fifo_flags #(
   parameter int DEPTH = 1024
) (
   // system
   input  wire logic        clk,
   input  wire logic        arst_n,
   // register bus
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   output logic             irq,
   // writer side
   input  wire logic        write_clk,
   input  wire logic        write_en_n,
   input  wire logic        load_n,
   input  wire logic [35:0] write_data_in,
   // reader side
   input  wire logic        read_clk,
   input  wire logic        read_en_n,
   output logic      [35:0] read_data_out,
   // resets and straps
   input  wire logic        master_reset_n,
   input  wire logic        partial_reset_n,
   input  wire logic        byte_order_select,
   input  wire logic        flag_timing_select,
   input  wire logic        parity_placement_select,
   input  wire logic        fall_through_mode,
   input  wire logic        width_match_enable,
   input  wire logic        input_width_select,
   input  wire logic        output_width_select,
   // flags
   output logic             full_flag_n,
   output logic             almost_empty_flag_n,
   output logic             almost_full_flag_n,
   output logic             half_full_flag_n
);
   localparam int CW = $clog2(DEPTH + 2);

   // ------------------------------------------------------------
   // pin sampling
   // ------------------------------------------------------------
   logic [13:0] pin_lvl;
   logic [13:0] pin_rise;
   logic [35:0] din;
   logic        wr_edge;
   logic        rd_edge;
   logic        s_wen_n;
   logic        s_ren_n;
   logic        s_ld_n;
   logic        s_mrs_n;
   logic        s_prs_n;
   logic        s_be;
   logic        s_pfm;
   logic        s_ip;
   logic        s_fall_through_mode;
   logic        s_bm;
   logic        s_iw;
   logic        s_ow;

   dcf_pin_sync #(.W(14)) u_pins (
      .clk    (clk),
      .arst_n (arst_n),
      .pin_in ({output_width_select, input_width_select, width_match_enable, fall_through_mode,
                parity_placement_select, flag_timing_select, byte_order_select, partial_reset_n,
                master_reset_n, load_n, read_en_n, write_en_n, read_clk, write_clk}),
      .lvl    (pin_lvl),
      .rise   (pin_rise)
   );

   dcf_pin_sync #(.W(36)) u_data (
      .clk    (clk),
      .arst_n (arst_n),
      .pin_in (write_data_in),
      .lvl    (din),
      .rise   ()
   );

   assign {s_ow, s_iw, s_bm, s_fall_through_mode, s_ip, s_pfm, s_be, s_prs_n, s_mrs_n, s_ld_n, s_ren_n, s_wen_n} = pin_lvl[13:2];
   assign wr_edge = pin_rise[0];
   assign rd_edge = pin_rise[1];

   // ------------------------------------------------------------
   // straps latched during master reset
   // ------------------------------------------------------------
   logic cfg_be;
   logic cfg_pfm;
   logic cfg_ip;
   logic cfg_fall_through_mode;
   logic cfg_bm;
   logic cfg_iw;
   logic cfg_ow;
   logic in_rst;
   logic clr;

   assign in_rst = !s_mrs_n;
   assign clr    = !s_mrs_n || !s_prs_n;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         {cfg_be, cfg_pfm, cfg_ip, cfg_fall_through_mode, cfg_bm, cfg_iw, cfg_ow} <= 7'h00;
      end else if (in_rst) begin
         cfg_be   <= s_be;
         cfg_pfm  <= s_pfm;
         cfg_ip   <= s_ip;
         cfg_fall_through_mode <= s_fall_through_mode;
         cfg_bm   <= s_bm;
         cfg_iw   <= s_iw;
         cfg_ow   <= s_ow;
      end
   end

   chk_straps_held: assert property (@(posedge clk) disable iff (!arst_n)
      s_mrs_n && $past(s_mrs_n) |-> $stable({cfg_be, cfg_pfm, cfg_ip, cfg_fall_through_mode, cfg_bm, cfg_iw, cfg_ow}))
      else $error("strap selection changed outside master reset");

   // ------------------------------------------------------------
   // occupancy and thresholds
   // ------------------------------------------------------------
   logic [35:0]   mem [DEPTH+1];
   logic [CW-1:0] count;
   logic [CW-1:0] next_count;
   logic [CW-1:0] wptr;
   logic [CW-1:0] rptr;
   logic [15:0]   ofs_empty;
   logic [15:0]   ofs_full;
   logic [16:0]   cnt17;
   logic [16:0]   cap17;
   logic [16:0]   half17;
   logic          ae_cond;
   logic          af_cond;
   logic          hf_cond;
   logic          is_full;
   logic          wr_go;
   logic          wr_take;
   logic          word_done;
   logic          rd_go;
   logic          pop;

   function automatic logic [CW-1:0] ptr_inc(input logic [CW-1:0] p);
      return (p == CW'(DEPTH)) ? '0 : p + CW'(1);
   endfunction : ptr_inc

   // fall-through mode counts the output register as one more word
   assign cap17   = 17'(DEPTH) + 17'(cfg_fall_through_mode);
   assign half17  = 17'(DEPTH / 2) + 17'(cfg_fall_through_mode);
   assign cnt17   = 17'(next_count);
   assign ae_cond = cnt17 <= ({1'b0, ofs_empty} + 17'(cfg_fall_through_mode));
   assign af_cond = (cnt17 + {1'b0, ofs_full}) >= cap17;
   assign hf_cond = cnt17 > half17;
   assign is_full = cnt17 == cap17;

   assign wr_go     = wr_edge && !s_wen_n && s_ld_n && !clr;
   assign wr_take   = wr_go && (17'(count) != cap17);
   assign rd_go     = rd_edge && !s_ren_n && !clr;

   always_comb begin
      next_count = count;
      if (word_done)
         next_count = next_count + CW'(1);
      if (pop)
         next_count = next_count - CW'(1);
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         count <= '0;
         wptr  <= '0;
         rptr  <= '0;
      end else if (clr) begin
         count <= '0;
         wptr  <= '0;
         rptr  <= '0;
      end else begin
         count <= next_count;
         if (word_done)
            wptr <= ptr_inc(wptr);
         if (pop)
            rptr <= ptr_inc(rptr);
      end
   end

   chk_no_overflow: assert property (@(posedge clk) disable iff (!arst_n)
      (s_mrs_n && s_prs_n && 17'(count) == cap17 && !rd_edge) |=> 17'(count) == cap17)
      else $error("stored count moved past capacity");

   // ------------------------------------------------------------
   // write side packing
   // ------------------------------------------------------------
   logic [2:0]  in_n;
   logic [5:0]  in_b;
   logic [2:0]  in_cnt;
   logic [35:0] in_acc;
   logic [35:0] piece_in;
   logic [35:0] next_acc;

   assign in_n      = dcf_pkg::dcf_pieces(cfg_bm && cfg_iw, cfg_ow);
   assign in_b      = dcf_pkg::dcf_bits(in_n);
   assign piece_in  = din & ((36'h1 << in_b) - 36'h1);
   assign word_done = wr_take && (in_cnt == in_n - 3'h1);

   // big-endian shifts earlier pieces upward, little-endian downward
   assign next_acc = cfg_be ? ((in_acc >> in_b) | (piece_in << (6'h24 - in_b)))
                            : ((in_acc << in_b) | piece_in);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         in_cnt <= '0;
         in_acc <= '0;
      end else if (clr) begin
         in_cnt <= '0;
         in_acc <= '0;
      end else if (wr_take) begin
         in_cnt <= word_done ? 3'h0 : in_cnt + 3'h1;
         in_acc <= next_acc;
      end
   end

   // data is stored as written, parity placement plays no part
   always_ff @(posedge clk) begin
      if (word_done)
         mem[wptr] <= next_acc;
   end

   // ------------------------------------------------------------
   // read side unpacking
   // ------------------------------------------------------------
   logic [2:0]  out_n;
   logic [5:0]  out_b;
   logic [2:0]  ob_left;
   logic [35:0] ob;
   logic [35:0] src;
   logic [35:0] out_mask;

   assign out_n    = dcf_pkg::dcf_pieces(cfg_bm && !cfg_iw, cfg_ow);
   assign out_b    = dcf_pkg::dcf_bits(out_n);
   assign out_mask = (36'h1 << out_b) - 36'h1;
   assign pop      = rd_go && (ob_left == 3'h0) && (count != '0);
   assign src      = (ob_left == 3'h0) ? mem[rptr] : ob;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ob            <= '0;
         ob_left       <= '0;
         read_data_out <= '0;
      end else if (clr) begin
         ob            <= '0;
         ob_left       <= '0;
         read_data_out <= '0;
      end else if (pop || (rd_go && ob_left != 3'h0)) begin
         ob_left <= (ob_left == 3'h0) ? out_n - 3'h1 : ob_left - 3'h1;
         if (cfg_be) begin
            read_data_out <= src & out_mask;
            ob            <= src >> out_b;
         end else begin
            read_data_out <= (src >> (6'h24 - out_b)) & out_mask;
            ob            <= src << out_b;
         end
      end
   end

   chk_out_width: assert property (@(posedge clk) disable iff (!arst_n)
      (s_mrs_n && out_n != 3'h1) |-> read_data_out[35:18] == 18'h0)
      else $error("narrow output drove upper data bits");

   chk_pass_through: assert property (@(posedge clk) disable iff (!arst_n)
      (s_mrs_n && s_prs_n && !cfg_bm && pop) |=> read_data_out == $past(mem[rptr]))
      else $error("full width word altered on the way out");

   // ------------------------------------------------------------
   // offset registers and parallel load
   // ------------------------------------------------------------
   logic [31:0] ld_value;
   logic        ld_sel;
   logic        ld_take;
   logic        bus_wr;

   dcf_parity_strip u_strip (
      .din          (din),
      .interspersed (cfg_ip),
      .value        (ld_value)
   );

   assign ld_take = wr_edge && !s_wen_n && !s_ld_n && s_mrs_n;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ofs_empty <= dcf_pkg::EMPTY_OFS_RST;
         ofs_full  <= dcf_pkg::FULL_OFS_RST;
         ld_sel    <= 1'b0;
      end else if (in_rst) begin
         ofs_empty <= dcf_pkg::EMPTY_OFS_RST;
         ofs_full  <= dcf_pkg::FULL_OFS_RST;
         ld_sel    <= 1'b0;
      end else if (ld_take) begin
         ld_sel <= !ld_sel;
         if (ld_sel)
            ofs_full <= ld_value[15:0];
         else
            ofs_empty <= ld_value[15:0];
      end else if (bus_wr && avs_address == dcf_pkg::A_OFFSET) begin
         ofs_empty <= avs_writedata[15:0];
         ofs_full  <= avs_writedata[dcf_pkg::OFS_FULL_LSB +: 16];
      end
   end

   // ------------------------------------------------------------
   // flags
   // ------------------------------------------------------------
   logic ff_s1;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         almost_empty_flag_n <= 1'b0;
      end else if (clr) begin
         almost_empty_flag_n <= 1'b0;
      end else if (cfg_pfm) begin
         if (rd_edge)
            almost_empty_flag_n <= !ae_cond;
      end else if (rd_edge && ae_cond) begin
         almost_empty_flag_n <= 1'b0;
      end else if (wr_edge && !ae_cond) begin
         almost_empty_flag_n <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         almost_full_flag_n <= 1'b1;
      end else if (clr) begin
         almost_full_flag_n <= 1'b1;
      end else if (cfg_pfm) begin
         if (wr_edge)
            almost_full_flag_n <= !af_cond;
      end else if (wr_edge && af_cond) begin
         almost_full_flag_n <= 1'b0;
      end else if (rd_edge && !af_cond) begin
         almost_full_flag_n <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         half_full_flag_n <= 1'b1;
      end else if (clr) begin
         half_full_flag_n <= 1'b1;
      end else if (wr_edge && hf_cond) begin
         half_full_flag_n <= 1'b0;
      end else if (rd_edge && !hf_cond) begin
         half_full_flag_n <= 1'b1;
      end
   end

   // full is active low, input-ready is active high when no room is left
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ff_s1       <= 1'b1;
         full_flag_n <= 1'b1;
      end else if (clr) begin
         ff_s1       <= !cfg_fall_through_mode;
         full_flag_n <= !cfg_fall_through_mode;
      end else if (wr_edge) begin
         ff_s1       <= cfg_fall_through_mode ? is_full : !is_full;
         full_flag_n <= ff_s1;
      end
   end

   chk_ae_std_level: assert property (@(posedge clk) disable iff (!arst_n)
      (cfg_pfm && !cfg_fall_through_mode && rd_edge && !clr) |=> almost_empty_flag_n == (17'(count) > {1'b0, ofs_empty}))
      else $error("almost-empty wrong against empty offset");

   chk_ae_fall_through_mode_level: assert property (@(posedge clk) disable iff (!arst_n)
      (cfg_pfm && cfg_fall_through_mode && rd_edge && !clr) |=> almost_empty_flag_n == (17'(count) > {1'b0, ofs_empty} + 17'h1))
      else $error("almost-empty wrong against offset plus one");

   chk_ae_async_src: assert property (@(posedge clk) disable iff (!arst_n)
      (!cfg_pfm && !clr && !rd_edge) |=> !$fell(almost_empty_flag_n))
      else $error("async almost-empty asserted without read edge");

   chk_af_sync_src: assert property (@(posedge clk) disable iff (!arst_n)
      (cfg_pfm && !clr && !wr_edge) |=> $stable(almost_full_flag_n))
      else $error("sync almost-full moved without write edge");

   chk_hf_edges: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(half_full_flag_n) |-> $past(rd_edge) || $past(clr))
      else $error("half-full released without read edge");

   chk_hf_thresh: assert property (@(posedge clk) disable iff (!arst_n)
      (wr_edge && !clr && cnt17 > half17) |=> !half_full_flag_n)
      else $error("half-full not set past half depth");

   chk_full_wclk: assert property (@(posedge clk) disable iff (!arst_n)
      (!clr && !wr_edge) |=> $stable(full_flag_n))
      else $error("full flag moved without write edge");

   // ------------------------------------------------------------
   // interrupt status
   // ------------------------------------------------------------
   logic [dcf_pkg::NST-1:0] status;
   logic [dcf_pkg::NST-1:0] mask;
   logic [dcf_pkg::NST-1:0] ev;
   logic [dcf_pkg::NST-1:0] next_status;
   logic [3:0]              flag_d;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         flag_d <= 4'hf;
      else
         flag_d <= {is_full, almost_empty_flag_n, almost_full_flag_n, half_full_flag_n};
   end

   always_comb begin
      ev                  = '0;
      ev[dcf_pkg::S_AE]   = flag_d[2] && !almost_empty_flag_n;
      ev[dcf_pkg::S_AF]   = flag_d[1] && !almost_full_flag_n;
      ev[dcf_pkg::S_HF]   = flag_d[0] && !half_full_flag_n;
      ev[dcf_pkg::S_FULL] = !flag_d[3] && is_full && !clr;
      ev[dcf_pkg::S_OVF]  = wr_go && !wr_take;
      next_status = status;
      if (bus_wr && avs_address == dcf_pkg::A_STATUS)
         next_status = status & ~avs_writedata[dcf_pkg::NST-1:0];
      next_status = next_status | ev;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         status <= dcf_pkg::STATUS_RST;
         mask   <= dcf_pkg::MASK_RST;
         irq    <= 1'b0;
      end else begin
         status <= next_status;
         irq    <= |(next_status & mask);
         if (bus_wr && avs_address == dcf_pkg::A_MASK)
            mask <= avs_writedata[dcf_pkg::NST-1:0];
      end
   end

   // ------------------------------------------------------------
   // avalon slave, one wait state per access
   // ------------------------------------------------------------
   logic [31:0] rd_mux;

   assign bus_wr = avs_write && !avs_waitrequest;

   always_comb begin
      if (avs_address == dcf_pkg::A_STATUS)
         rd_mux = 32'(status);
      else if (avs_address == dcf_pkg::A_MASK)
         rd_mux = 32'(mask);
      else if (avs_address == dcf_pkg::A_CONFIG)
         rd_mux = 32'({cfg_ow, cfg_iw, cfg_bm, cfg_fall_through_mode, cfg_ip, cfg_pfm, cfg_be});
      else if (avs_address == dcf_pkg::A_LEVEL)
         rd_mux = {12'h000, full_flag_n, almost_empty_flag_n, almost_full_flag_n, half_full_flag_n, 16'(count)};
      else if (avs_address == dcf_pkg::A_OFFSET)
         rd_mux = {ofs_full, ofs_empty};
      else
         rd_mux = 32'h0000_0000;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= '0;
      end else if ((avs_read || avs_write) && avs_waitrequest) begin
         avs_waitrequest <= 1'b0;
         avs_readdata    <= rd_mux;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end
endmodule : dcf_fifo_flags
`default_nettype wire

/* File: dcf_parity_strip.sv */
// offset value extraction from a parallel load word
`timescale 1ns/1ps
`default_nettype none
module dcf_parity_strip (
   // load word and placement
   input  wire logic [35:0] din,
   input  wire logic        interspersed,
   // offset value
   output logic      [31:0] value
);
   // parity bits are skipped or the top nibble is dropped
   assign value = interspersed ? {din[34:27], din[25:18], din[16:9], din[7:0]} : din[31:0];
endmodule : dcf_parity_strip
`default_nettype wire

/* File: dcf_pin_sync.sv */
// three-stage pin synchroniser with agreement filter and rise pulse
`timescale 1ns/1ps
`default_nettype none
module dcf_pin_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         arst_n,
   // pins and filtered view
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] lvl,
   output logic      [W-1:0] rise
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end else begin
         s1 <= pin_in;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // a bit changes only once stages two and three agree
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         lvl  <= '0;
         rise <= '0;
      end else begin
         lvl  <= (s2 & s3) | (lvl & (s2 ^ s3));
         rise <= s2 & s3 & ~lvl;
      end
   end
endmodule : dcf_pin_sync
`default_nettype wire

/* File: dcf_pkg.sv */
// shared constants and helpers for the dual-clock flag fifo
package dcf_pkg;

   // ------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [4:0] A_STATUS = 5'h00;
   localparam logic [4:0] A_MASK   = 5'h04;
   localparam logic [4:0] A_CONFIG = 5'h08;
   localparam logic [4:0] A_LEVEL  = 5'h0c;
   localparam logic [4:0] A_OFFSET = 5'h10;

   // ------------------------------------------------------------
   // status bit positions and reset values
   // ------------------------------------------------------------
   localparam int S_AE   = 0;
   localparam int S_AF   = 1;
   localparam int S_HF   = 2;
   localparam int S_FULL = 3;
   localparam int S_OVF  = 4;
   localparam int NST    = 5;
   localparam logic [4:0]  STATUS_RST    = 5'h00;
   localparam logic [4:0]  MASK_RST      = 5'h00;
   localparam logic [15:0] EMPTY_OFS_RST = 16'h007f;
   localparam logic [15:0] FULL_OFS_RST  = 16'h007f;
   localparam int OFS_FULL_LSB = 16;

   // ------------------------------------------------------------
   // bus matching helpers
   // ------------------------------------------------------------
   function automatic logic [2:0] dcf_pieces(input logic narrow, input logic nine);
      if (!narrow)
         return 3'h1;
      return nine ? 3'h4 : 3'h2;
   endfunction : dcf_pieces

   function automatic logic [5:0] dcf_bits(input logic [2:0] pieces);
      if (pieces == 3'h4)
         return 6'h09;
      return (pieces == 3'h2) ? 6'h12 : 6'h24;
   endfunction : dcf_bits

endpackage : dcf_pkg

/* File: dual_clock_fifo_flags_config_tb.sv */
// self-checking bench for the dual-clock flag fifo
`timescale 1ns/1ps
`default_nettype none
module dual_clock_fifo_flags_config_tb;
   logic clk, arst_n = 0, avs_read = 0, avs_write = 0, wr_go = 0, rd_go = 0;
   logic irq, avs_waitrequest, write_clk, read_clk, write_en_n, read_en_n;
   logic full_flag_n, almost_empty_flag_n, almost_full_flag_n, half_full_flag_n;
   logic master_reset_n = 1, partial_reset_n = 1, byte_order_select = 0, flag_timing_select = 0;
   logic parity_placement_select = 0, fall_through_mode = 0;
   logic [4:0] avs_address = 0;
   logic [31:0] avs_writedata = 0, avs_readdata, seed = 32'h71bb;
   logic [35:0] wdata = 0, write_data_in, read_data_out;
   int fails = 0, num_checks = 0;
   dcf_fifo_flags #(.DEPTH(16)) dcf_fifo_flags_i (.clk(clk), .arst_n(arst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .irq(irq), .write_clk(write_clk), .write_en_n(write_en_n),
      .load_n(1'b1), .write_data_in(write_data_in), .read_clk(read_clk), .read_en_n(read_en_n),
      .read_data_out(read_data_out), .master_reset_n(master_reset_n), .partial_reset_n(partial_reset_n),
      .byte_order_select(byte_order_select), .flag_timing_select(flag_timing_select),
      .parity_placement_select(parity_placement_select), .fall_through_mode(fall_through_mode),
      .width_match_enable(1'b0), .input_width_select(1'b0), .output_width_select(1'b0),
      .full_flag_n(full_flag_n), .almost_empty_flag_n(almost_empty_flag_n),
      .almost_full_flag_n(almost_full_flag_n), .half_full_flag_n(half_full_flag_n));
   dcf_far_end dcf_far_end_i (.wr_go(wr_go), .rd_go(rd_go), .wdata(wdata), .write_clk(write_clk),
      .read_clk(read_clk), .write_en_n(write_en_n), .read_en_n(read_en_n), .write_data_in(write_data_in));
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction : xs
   function automatic logic [31:0] lvl(input int c, input int cap, input logic f);
      logic hf_n, af_n, ae_n, ff_n;
      hf_n = f ? (c < (cap - 1) / 2 + 2) : (c < cap / 2 + 1);
      af_n = c < cap - 3;
      ae_n = f ? (c > 3) : (c > 2);
      ff_n = f ? (c >= cap) : (c < cap);
      return {12'h0, ff_n, ae_n, af_n, hf_n, c[15:0]};
   endfunction : lvl
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask : bus
   task automatic link(input logic wr, input logic [35:0] d);
      @(posedge clk);
      wdata <= d;
      wr_go <= wr;
      rd_go <= !wr;
      if (wr) @(negedge write_clk);
      else @(negedge read_clk);
      @(posedge clk);
      wr_go <= 1'b0;
      rd_go <= 1'b0;
      repeat (64) @(posedge clk);
   endtask : link
   task automatic look(input int c, input int cap, input logic f);
      logic [31:0] q, e;
      e = lvl(c, cap, f);
      bus(1'b0, dcf_pkg::A_LEVEL, 32'h0, q);
      chk(36'(q), 36'(e));
      chk(36'({full_flag_n, almost_empty_flag_n, almost_full_flag_n, half_full_flag_n}), 36'(e[19:16]));
   endtask : look
   // ------------------------------------------------------------
   // scenario: straps, fill past full, irq, drain
   // ------------------------------------------------------------
   task automatic run(input logic [3:0] s);
      int cap;
      logic [31:0] q;
      logic [35:0] w[$];
      @(posedge clk);
      {parity_placement_select, fall_through_mode, flag_timing_select, byte_order_select} <= s;
      master_reset_n <= 1'b0;
      repeat (12) @(posedge clk);
      master_reset_n <= 1'b1;
      repeat (10) @(posedge clk);
      cap = 16 + int'(s[2]);
      bus(1'b0, dcf_pkg::A_CONFIG, 32'h0, q);
      chk(36'(q), {32'h0, s[2], s[3], s[1], s[0]});
      bus(1'b1, dcf_pkg::A_OFFSET, 32'h0003_0002, q);
      // partial reset clears flags and count but must keep the offsets just written
      partial_reset_n <= 1'b0;
      repeat (12) @(posedge clk);
      partial_reset_n <= 1'b1;
      repeat (10) @(posedge clk);
      bus(1'b1, dcf_pkg::A_MASK, 32'h1 << dcf_pkg::S_HF, q);
      bus(1'b1, dcf_pkg::A_STATUS, 32'h1f, q);
      look(0, cap, s[2]);
      for (int c = 1; c <= cap + 1; c++) begin
         seed = xs(seed);
         if (c <= cap) w.push_back({seed[3:0], seed});
         link(1'b1, {seed[3:0], seed});
         look((c > cap) ? cap : c, cap, s[2]);
      end
      bus(1'b0, dcf_pkg::A_STATUS, 32'h0, q);
      chk(36'(q & 32'h1e), 36'h1e);
      chk(36'(irq), 36'h1);
      bus(1'b1, dcf_pkg::A_STATUS, 32'h1f, q);
      repeat (2) @(posedge clk);
      chk(36'(irq), 36'h0);
      for (int c = cap - 1; c >= 0; c--) begin
         link(1'b0, 36'h0);
         chk(read_data_out, w.pop_front());
         look(c, cap, s[2]);
      end
      bus(1'b1, dcf_pkg::A_MASK, 32'h0, q);
      bus(1'b0, 5'h14, 32'h0, q);
      chk(36'({q[30:0], irq}), 36'h0);
   endtask : run
   task automatic conclude;
      if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      repeat (60000) @(posedge clk);
      fails++;
      conclude();
   end
   initial begin
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      run(4'b0010);
      run(4'b1101);
      conclude();
   end
endmodule : dual_clock_fifo_flags_config_tb
`default_nettype wire
